// File: tb/cmmc_engine_model.sv
`timescale 1ns/1ps

// stands in for the reception storage and transmission engines
module cmmc_engine_model
#(
    parameter int NUM_MB = 24
)
(
    input wire logic clk,
    output logic [NUM_MB-1:0] rx_eof6,
    output logic [NUM_MB-1:0] rx_store_start,
    output logic [NUM_MB-1:0] rx_store_done,
    output logic [NUM_MB-1:0] tx_start,
    output logic [NUM_MB-1:0] tx_done,
    output logic [NUM_MB-1:0] tx_fail
);
    // event rows: 0 eof6, 1 store start, 2 store done, 3 tx start, 4 tx done, 5 tx fail
    logic [5:0][NUM_MB-1:0] ev_q;

    initial
    begin
        ev_q = '0;
    end

    // each event line is a one-cycle pulse per mailbox
    assign rx_eof6 = ev_q[0];
    assign rx_store_start = ev_q[1];
    assign rx_store_done = ev_q[2];
    assign tx_start = ev_q[3];
    assign tx_done = ev_q[4];
    assign tx_fail = ev_q[5];

    // one pulse after gap idle cycles, so a slow engine and a prompt one both show
    task automatic pulse(input int kind, input int mb, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        ev_q[kind][mb] <= 1'b1;
        @(posedge clk);
        ev_q[kind][mb] <= 1'b0;
        #1;
    endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps

// register-level bench for the mailbox control block
module tb;
    localparam int NMB = 24; // 24 live mailboxes leave indexes 24 to 31 unmapped

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [NMB-1:0] rx_eof6, rx_store_start, rx_store_done;
    logic [NMB-1:0] tx_start, tx_done, tx_fail;
    logic [NMB-1:0] mb_rx_enable, mb_tx_request, mb_single_attempt;
    int num_errors = 0;
    int compares = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    // far-side engine events
    cmmc_engine_model #(.NUM_MB(NMB)) eng (.clk(clk), .rx_eof6(rx_eof6), .rx_store_start(rx_store_start),
        .rx_store_done(rx_store_done), .tx_start(tx_start), .tx_done(tx_done), .tx_fail(tx_fail));

    cmmc_mailbox_ctrl #(.NUM_MB(NMB), .ADDR_W(5)) uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_eof6(rx_eof6), .rx_store_start(rx_store_start), .rx_store_done(rx_store_done),
        .tx_start(tx_start), .tx_done(tx_done), .tx_fail(tx_fail), .mb_rx_enable(mb_rx_enable),
        .mb_tx_request(mb_tx_request), .mb_single_attempt(mb_single_attempt));

    // verdict and end of run
    task automatic summarize();
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // compare one byte, four-state exact
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write; ends after the effect has settled
    task automatic wr(input int mb, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= 5'(mb);
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // one-cycle read; data is looked at in the cycle after the strobe
    task automatic rd(input int mb, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= 5'(mb);
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // a hang ends the run as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd(0, 8'h00);
        chk({5'h00, |mb_rx_enable, |mb_tx_request, |mb_single_attempt}, 8'h00);
        // receive set-up, empty positions, unmapped index
        wr(1, 8'h68);
        rd(1, 8'h40);
        // read data stand one cycle only, then fall back to zero
        @(posedge clk);
        #1;
        chk(reg_rdata, 8'h00);
        chk({7'h00, mb_rx_enable[1]}, 8'h01);
        wr(30, 8'h40);
        rd(30, 8'h00);
        // store in progress: clear of new data refused, other flags written as one
        eng.pulse(1, 1, 0);
        rd(1, 8'h43);
        wr(1, 8'h46);
        rd(1, 8'h43);
        eng.pulse(2, 1, 3); // mailbox data left unread while storing
        rd(1, 8'h41);
        wr(1, 8'h47);
        rd(1, 8'h41);
        // overrun while new data unread; early clear of lost is refused
        eng.pulse(0, 1, 0);
        wr(1, 8'h43);
        rd(1, 8'h45);
        repeat (6) @(posedge clk);
        wr(1, 8'h43);
        rd(1, 8'h41);
        wr(1, 8'h46);
        rd(1, 8'h40);
        wr(1, 8'h00);
        rd(1, 8'h00);
        chk({7'h00, mb_rx_enable[1]}, 8'h00);
        // single-attempt reception: receives once, never marks loss
        wr(2, 8'h50);
        chk({6'h00, mb_rx_enable[2], mb_single_attempt[2]}, 8'h03);
        eng.pulse(1, 2, 0);
        eng.pulse(2, 2, 0);
        chk({6'h00, mb_rx_enable[2], mb_single_attempt[2]}, 8'h01);
        eng.pulse(0, 2, 0);
        rd(2, 8'h51);
        // dropping receive config re-arms the single-attempt mailbox
        wr(2, 8'h00);
        wr(2, 8'h50);
        chk({6'h00, mb_rx_enable[2], mb_single_attempt[2]}, 8'h03);
        // transmit: failure then retry and success
        wr(3, 8'h80);
        chk({7'h00, mb_tx_request[3]}, 8'h01);
        rd(3, 8'h80);
        eng.pulse(3, 3, 0);
        rd(3, 8'h82);
        eng.pulse(5, 3, 0);
        rd(3, 8'h80);
        eng.pulse(3, 3, 1);
        eng.pulse(4, 3, 4);
        rd(3, 8'h81);
        chk({7'h00, mb_tx_request[3]}, 8'h00);
        wr(3, 8'h00);
        rd(3, 8'h01);
        wr(3, 8'h00);
        rd(3, 8'h00);
        // abort before start, then clears by zero only
        wr(4, 8'h80);
        wr(4, 8'h00);
        rd(4, 8'h04);
        wr(4, 8'h05);
        rd(4, 8'h04);
        wr(4, 8'h01);
        rd(4, 8'h00);
        // abort while active, ending in failure
        wr(5, 8'h80);
        eng.pulse(3, 5, 0);
        wr(5, 8'h00);
        rd(5, 8'h02);
        eng.pulse(5, 5, 0);
        rd(5, 8'h04);
        // abort too late: frame completes
        wr(6, 8'h80);
        eng.pulse(3, 6, 0);
        wr(6, 8'h00);
        eng.pulse(4, 6, 2);
        rd(6, 8'h01);
        // single-attempt transmission: failure and success
        wr(7, 8'h90);
        eng.pulse(3, 7, 0);
        eng.pulse(5, 7, 0);
        rd(7, 8'h94);
        chk({7'h00, mb_tx_request[7]}, 8'h00);
        wr(8, 8'h90);
        eng.pulse(3, 8, 0);
        eng.pulse(4, 8, 1);
        rd(8, 8'h91);
        summarize();
    end
endmodule

// File: verilog/cmmc_consts.svh
`ifndef CMMC_CONSTS_SVH
`define CMMC_CONSTS_SVH

// number of mailboxes and width of the register index
`define CMMC_NUM_MB 32
`define CMMC_ADDR_W 5

// control register reset value
`define CMMC_CTRL_RESET 8'h00

// shared low positions: receive view / transmit view
`define CMMC_BIT_NEW_SENT 0
`define CMMC_BIT_INV_ACTIVE 1
`define CMMC_BIT_LOST_ABT 2
// positions with no storage
`define CMMC_BIT_UNUSED_A 3
`define CMMC_BIT_UNUSED_B 5
// configuration positions
`define CMMC_BIT_SINGLE_ATTEMPT_ENABLE 4
`define CMMC_BIT_RXCFG 6
`define CMMC_BIT_TXCFG 7

// message-lost clear guard after the sixth end-of-frame bit, in bus clocks
`define CMMC_LOST_HOLD_CYC 5

`endif

// File: verilog/cmmc_hold_timer.sv
`timescale 1ns/1ps
`include "cmmc_consts.svh"

// busy for a fixed number of cycles after a start pulse
module cmmc_hold_timer
#(
    parameter int CYCLES = `CMMC_LOST_HOLD_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    output logic busy
);

    localparam int CW = $clog2(CYCLES + 1);

    // remaining guarded cycles
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // reload on start, otherwise count down to zero
    always_comb
    begin
        cnt_d = cnt_q;
        if (start)
        begin
            cnt_d = CW'(CYCLES);
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    // counter register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != '0);

endmodule

// File: verilog/cmmc_mailbox_ctrl.sv
// Notes on behaviour
// RULE1: transmit mailbox shows transmit flags in low bits
// RULE2: receiving flag high while storing, then clears
// RULE3: software ignores contents while receiving flag high
// RULE4: new flag sets together with receiving flag
// RULE5: writing 0 clears new flag, not while storing
// RULE6: lost flag marks overwritten or overrun message
// RULE7: sent flag sets on successful transmission
// RULE8: sent and transmit config never cleared together
// RULE9: software clears transmit config before sent flag
// RULE10: software clears sent flag before new request
// RULE11: active flag sets when transmission begins
// RULE12: active clears on arbitration loss, error, completion
// RULE13: abort flag high only after completed abort
// RULE14: bits 3 and 5 read zero, no storage
// RULE15: single attempt bit selects one-shot operation
// RULE16: receive config bit enables reception
// RULE17: transmit config bit requests transmission
// RULE18: software clears receive flags with receive config
// RULE19: status flags ignore writes of one
// RULE20: software writes one to flags it keeps
// RULE21: lost sets at sixth end-of-frame bit if unread
// RULE22: lost clear ignored five cycles after that bit
// RULE23: abort flag sets on early abort or failure
// RULE24: one-shot transmit no retry, sent or abort
`timescale 1ns/1ps
`include "cmmc_consts.svh"

module cmmc_mailbox_ctrl
#(
    parameter int NUM_MB = `CMMC_NUM_MB,
    parameter int ADDR_W = `CMMC_ADDR_W
)
(
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // reception storage engine events, one bit per mailbox
    input wire logic [NUM_MB-1:0] rx_eof6,
    input wire logic [NUM_MB-1:0] rx_store_start,
    input wire logic [NUM_MB-1:0] rx_store_done,
    // transmission engine events, one bit per mailbox
    input wire logic [NUM_MB-1:0] tx_start,
    input wire logic [NUM_MB-1:0] tx_done,
    input wire logic [NUM_MB-1:0] tx_fail,
    // mailbox configuration seen by the engines
    output logic [NUM_MB-1:0] mb_rx_enable,
    output logic [NUM_MB-1:0] mb_tx_request,
    output logic [NUM_MB-1:0] mb_single_attempt
);

    // per-mailbox flag and configuration state
    logic [NUM_MB-1:0] new_q, new_d;          // new message flag
    logic [NUM_MB-1:0] inv_q, inv_d;          // reception in progress flag
    logic [NUM_MB-1:0] lost_q, lost_d;        // message lost flag
    logic [NUM_MB-1:0] sent_q, sent_d;        // transmit complete flag
    logic [NUM_MB-1:0] active_q, active_d;    // transmit in progress flag
    logic [NUM_MB-1:0] abt_q, abt_d;          // abort complete flag
    logic [NUM_MB-1:0] pend_q, pend_d;        // abort requested during transmission
    logic [NUM_MB-1:0] single_attempt_enable_q, single_attempt_enable_d;  // single attempt enable
    logic [NUM_MB-1:0] used_q, used_d;        // one-shot reception already taken
    logic [NUM_MB-1:0] rxcfg_q, rxcfg_d;      // receive configure bit
    logic [NUM_MB-1:0] txcfg_q, txcfg_d;      // transmit configure bit
    logic [7:0] rdata_q, rdata_d;             // read data register
    // lost-clear guard per mailbox
    logic [NUM_MB-1:0] lost_start;
    logic [NUM_MB-1:0] lost_hold;

    // transmit view when not receive-configured and any transmit state is live
    function automatic cmmc_pkg::cmmc_view_t mb_view(
        input logic rx,
        input logic tx,
        input logic sent,
        input logic act,
        input logic abt
    );
        mb_view = cmmc_pkg::CMMC_VIEW_RX;
        if (!rx && (tx || sent || act || abt))
        begin
            mb_view = cmmc_pkg::CMMC_VIEW_TX;
        end
    endfunction

    // compose one control register byte as software reads it
    function automatic logic [7:0] mb_byte(
        input cmmc_pkg::cmmc_view_t view,
        input logic [2:0] rx_flags,
        input logic [2:0] tx_flags,
        input logic one,
        input logic rx,
        input logic tx
    );
        mb_byte = 8'h00;
        mb_byte[`CMMC_BIT_NEW_SENT] = (view == cmmc_pkg::CMMC_VIEW_TX) ? tx_flags[0] : rx_flags[0];
        mb_byte[`CMMC_BIT_INV_ACTIVE] = (view == cmmc_pkg::CMMC_VIEW_TX) ? tx_flags[1] : rx_flags[1];
        mb_byte[`CMMC_BIT_LOST_ABT] = (view == cmmc_pkg::CMMC_VIEW_TX) ? tx_flags[2] : rx_flags[2];
        mb_byte[`CMMC_BIT_SINGLE_ATTEMPT_ENABLE] = one;
        mb_byte[`CMMC_BIT_RXCFG] = rx;
        mb_byte[`CMMC_BIT_TXCFG] = tx;
    endfunction

    // lost-clear guard timers, one per mailbox
    for (genvar g = 0; g < NUM_MB; g++)
    begin : g_hold
        cmmc_hold_timer #(
            .CYCLES(`CMMC_LOST_HOLD_CYC)
        ) u_hold (
            .clk(clk),
            .resetn(resetn),
            .start(lost_start[g]),
            .busy(lost_hold[g])
        );
    end

    // next state of every mailbox: software part first, engine events override
    always_comb
    begin
        logic hit;
        cmmc_pkg::cmmc_view_t view;
        hit = 1'b0;
        view = cmmc_pkg::CMMC_VIEW_RX;
        new_d = new_q;
        inv_d = inv_q;
        lost_d = lost_q;
        sent_d = sent_q;
        active_d = active_q;
        abt_d = abt_q;
        pend_d = pend_q;
        single_attempt_enable_d = single_attempt_enable_q;
        used_d = used_q;
        rxcfg_d = rxcfg_q;
        txcfg_d = txcfg_q;
        lost_start = '0;
        for (int j = 0; j < NUM_MB; j++)
        begin
            hit = reg_wr && (reg_addr == ADDR_W'(j));
            view = mb_view(rxcfg_q[j], txcfg_q[j], sent_q[j], active_q[j], abt_q[j]);
            // software write: configuration bits store as written
            if (hit)
            begin
                single_attempt_enable_d[j] = reg_wdata[`CMMC_BIT_SINGLE_ATTEMPT_ENABLE]; // RULE15
                rxcfg_d[j] = reg_wdata[`CMMC_BIT_RXCFG]; // RULE16
                txcfg_d[j] = reg_wdata[`CMMC_BIT_TXCFG]; // RULE17
                if (view == cmmc_pkg::CMMC_VIEW_TX)
                begin
                    // sent clears only once transmit config is already 0
                    if (!reg_wdata[`CMMC_BIT_NEW_SENT] && !txcfg_q[j])
                    begin
                        sent_d[j] = 1'b0; // RULE8
                    end
                    // writing 1 leaves the abort flag alone
                    if (!reg_wdata[`CMMC_BIT_LOST_ABT])
                    begin
                        abt_d[j] = 1'b0; // RULE19
                    end
                    // withdrawing a request aborts it
                    if (txcfg_q[j] && !reg_wdata[`CMMC_BIT_TXCFG])
                    begin
                        if (active_q[j])
                        begin
                            pend_d[j] = 1'b1;
                        end
                        else if (!sent_q[j])
                        begin
                            abt_d[j] = 1'b1; // RULE23
                        end
                    end
                end
                else
                begin
                    // new flag cannot be cleared while storing
                    if (!reg_wdata[`CMMC_BIT_NEW_SENT] && !inv_q[j])
                    begin
                        new_d[j] = 1'b0; // RULE5
                    end
                    // lost flag guarded after the sixth end-of-frame bit
                    if (!reg_wdata[`CMMC_BIT_LOST_ABT] && !lost_hold[j])
                    begin
                        lost_d[j] = 1'b0; // RULE22
                    end
                    // dropping receive config re-arms one-shot reception
                    if (!reg_wdata[`CMMC_BIT_RXCFG])
                    begin
                        used_d[j] = 1'b0;
                    end
                end
            end
            // overwrite or overrun of an unread message, not in one-shot mode
            if (rx_eof6[j] && new_q[j] && !single_attempt_enable_q[j])
            begin
                lost_d[j] = 1'b1; // RULE21 RULE6
                lost_start[j] = 1'b1; // RULE22
            end
            // storage starts: both flags rise together
            if (rx_store_start[j] && mb_rx_enable[j])
            begin
                inv_d[j] = 1'b1; // RULE2
                new_d[j] = 1'b1; // RULE4
                used_d[j] = single_attempt_enable_q[j]; // RULE15
            end
            // storage finished: message valid at once
            if (rx_store_done[j])
            begin
                inv_d[j] = 1'b0; // RULE2
            end
            // transmission begins
            if (tx_start[j])
            begin
                active_d[j] = 1'b1; // RULE11
            end
            // successful completion
            if (tx_done[j])
            begin
                active_d[j] = 1'b0; // RULE12
                sent_d[j] = 1'b1; // RULE7
                pend_d[j] = 1'b0; // RULE13
            end
            // arbitration loss or bus error
            if (tx_fail[j])
            begin
                active_d[j] = 1'b0; // RULE12
                if (pend_q[j] || single_attempt_enable_q[j])
                begin
                    abt_d[j] = 1'b1; // RULE23 RULE24
                    pend_d[j] = 1'b0;
                end
            end
        end
    end

    // read data stand in the cycle after the read strobe only
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd && (int'(reg_addr) < NUM_MB))
        begin
            rdata_d = mb_byte(
                mb_view(rxcfg_q[reg_addr], txcfg_q[reg_addr], sent_q[reg_addr],
                        active_q[reg_addr], abt_q[reg_addr]),
                {lost_q[reg_addr], inv_q[reg_addr], new_q[reg_addr]},
                {abt_q[reg_addr], active_q[reg_addr], sent_q[reg_addr]},
                single_attempt_enable_q[reg_addr], rxcfg_q[reg_addr], txcfg_q[reg_addr]); // RULE1 RULE14
        end
    end

    // state registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            new_q <= '0;
            inv_q <= '0;
            lost_q <= '0;
            sent_q <= '0;
            active_q <= '0;
            abt_q <= '0;
            pend_q <= '0;
            single_attempt_enable_q <= '0;
            used_q <= '0;
            rxcfg_q <= '0;
            txcfg_q <= '0;
            rdata_q <= `CMMC_CTRL_RESET;
        end
        else
        begin
            new_q <= new_d;
            inv_q <= inv_d;
            lost_q <= lost_d;
            sent_q <= sent_d;
            active_q <= active_d;
            abt_q <= abt_d;
            pend_q <= pend_d;
            single_attempt_enable_q <= single_attempt_enable_d;
            used_q <= used_d;
            rxcfg_q <= rxcfg_d;
            txcfg_q <= txcfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    // receive when configured, not for transmit, one-shot not yet used
    assign mb_rx_enable = rxcfg_q & ~txcfg_q & ~used_q; // RULE16 RULE15
    // request transmission until sent or aborted
    assign mb_tx_request = txcfg_q & ~rxcfg_q & ~sent_q & ~abt_q; // RULE17 RULE10
    // engine must not retry when set
    assign mb_single_attempt = single_attempt_enable_q; // RULE24

    // reads of 1 of the two storage-less positions never happen
    AST_ZERO_BITS: assert property (@(posedge clk) disable iff (!resetn) // RULE14
        reg_rd |=> (reg_rdata[`CMMC_BIT_UNUSED_A] == 1'b0) && (reg_rdata[`CMMC_BIT_UNUSED_B] == 1'b0))
        else $error("unused control bits read as one");

    // per-mailbox checks
    for (genvar g = 0; g < NUM_MB; g++)
    begin : g_chk
        AST_TX_VIEW: assert property (@(posedge clk) disable iff (!resetn) // RULE1
            (reg_rd && reg_addr == ADDR_W'(g) && txcfg_q[g] && !rxcfg_q[g])
            |=> (reg_rdata[2:0] == $past({abt_q[g], active_q[g], sent_q[g]})))
            else $error("transmit mailbox did not show transmit flags");
        AST_INV_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // RULE2
            rx_store_done[g] |=> !inv_q[g])
            else $error("reception flag stayed high after storage");
        AST_NEW_WITH_INV: assert property (@(posedge clk) disable iff (!resetn) // RULE4
            $rose(inv_q[g]) |-> new_q[g])
            else $error("new flag not set with reception flag");
        AST_NEW_PROTECT: assert property (@(posedge clk) disable iff (!resetn) // RULE5
            (reg_wr && reg_addr == ADDR_W'(g) && inv_q[g] && new_q[g]) |=> new_q[g])
            else $error("new flag cleared while storing");
        AST_NEW_W1: assert property (@(posedge clk) disable iff (!resetn) // RULE19
            (reg_wr && reg_addr == ADDR_W'(g) && !new_q[g] && !rx_store_start[g]) |=> !new_q[g])
            else $error("software write set the new flag");
        AST_SENT_SET: assert property (@(posedge clk) disable iff (!resetn) // RULE7
            tx_done[g] |=> sent_q[g] && !active_q[g])
            else $error("sent flag not set on completion");
        AST_NO_DOUBLE_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // RULE8
            (reg_wr && reg_addr == ADDR_W'(g) && txcfg_q[g] && sent_q[g]) |=> sent_q[g])
            else $error("sent and transmit config cleared together");
        AST_ACTIVE_SET: assert property (@(posedge clk) disable iff (!resetn) // RULE11
            (tx_start[g] && !tx_done[g] && !tx_fail[g]) |=> active_q[g])
            else $error("active flag not set at transmission start");
        AST_ACTIVE_CLR: assert property (@(posedge clk) disable iff (!resetn) // RULE12
            ((tx_done[g] || tx_fail[g]) && !tx_start[g]) |=> !active_q[g])
            else $error("active flag not cleared");
        AST_ABT_SINGLE_ATTEMPT_ENABLE: assert property (@(posedge clk) disable iff (!resetn) // RULE24
            (tx_fail[g] && single_attempt_enable_q[g]) |=> abt_q[g] && !mb_tx_request[g])
            else $error("one-shot failure did not abort");
        AST_LOST_HOLD: assert property (@(posedge clk) disable iff (!resetn) // RULE22
            (rx_eof6[g] && new_q[g] && !single_attempt_enable_q[g]) |=> lost_q[g] [*5])
            else $error("lost flag cleared inside guard window");
        AST_SINGLE_ATTEMPT_ENABLE_RX: assert property (@(posedge clk) disable iff (!resetn) // RULE15
            (rx_store_start[g] && mb_rx_enable[g] && single_attempt_enable_q[g] && !reg_wr) |=> !mb_rx_enable[g])
            else $error("one-shot mailbox still receiving");
        COV_LOST: cover property (@(posedge clk) disable iff (!resetn)
            rx_eof6[g] && new_q[g] && !single_attempt_enable_q[g]);
        COV_SENT: cover property (@(posedge clk) disable iff (!resetn)
            tx_start[g] ##[1:50] tx_done[g]);
        COV_ABORT: cover property (@(posedge clk) disable iff (!resetn)
            pend_q[g] ##[1:50] abt_q[g]);
    end

endmodule

// File: verilog/cmmc_pkg.sv
package cmmc_pkg;

    // which flag set the shared low positions of a control register show
    typedef enum logic
    {
        CMMC_VIEW_RX = 1'b0,
        CMMC_VIEW_TX = 1'b1
    } cmmc_view_t;

endpackage
